// *** pmw_pkg.sv ***
// Constants and carrier types for the power-mode sequencer and watchdog.
// Assumes a 200 MHz system clock; the slow clock arrives as a sampled level.
package pmw_pkg;
  localparam logic [3:0] WDC_OFFSET = 4'hf;
  localparam int BIT_POR = 7;
  localparam int BIT_IE = 6;
  localparam int BIT_IF = 3;
  localparam int BIT_RF = 2;
  localparam int BIT_RE = 1;
  localparam int BIT_RESTART = 0;
  localparam logic [7:0] WDC_RESET = 8'h80;
  localparam logic [7:0] WDC_WMASK = 8'h43;
  // Slow clock periods: interval exponents 12,15,18,21 and the reset gap
  localparam int WD_SEL_W = 2;
  localparam logic [1:0] WD_SEL_RESET = 2'h0;
  localparam logic [9:0] WD_RESET_GAP = 10'h200;
  localparam logic [22:0] WD_TMO_0 = 23'h001000;
  localparam logic [22:0] WD_TMO_1 = 23'h008000;
  localparam logic [22:0] WD_TMO_2 = 23'h040000;
  localparam logic [22:0] WD_TMO_3 = 23'h200000;
  localparam logic [15:0] RESUME_ADDR = 16'h8000;
  localparam int STARTUP_US = 2000;
  localparam int CLK_MHZ = 200;
  localparam int STARTUP_CYC = STARTUP_US * CLK_MHZ;
  localparam int STARTUP_CNT_W = 20;
  localparam logic [3:0] CTL_OFFSET = 4'he;
  localparam logic [7:0] CTL_RESET = 8'h00;

  typedef enum logic [4:0] {
    PMW_BROWNOUT = 5'h01,
    PMW_CPU = 5'h02,
    PMW_ANALOG = 5'h04,
    PMW_SLEEP = 5'h08,
    PMW_CHGWAIT = 5'h10
  } pmw_mode_t;

  typedef struct packed {
    logic irq_ext;
    logic irq_int;
    logic irq_serial;
    logic port_pin;
    logic charger;
  } pmw_wake_t;

  typedef struct packed {
    pmw_mode_t mode;
    logic [7:0] wdc;
    logic [7:0] ctl;
    logic [22:0] wd_cnt;
    logic wd_armed;
    logic [9:0] gap_cnt;
    logic [STARTUP_CNT_W-1:0] su_cnt;
    logic slow_d;
    logic [7:0] rdata;
    logic wd_rst;
    logic bo_irq;
    logic halt;
    logic slow_analog_clock_en;
    logic [15:0] resume;
    logic ld_resume;
    logic stop_pend;
  } pmw_state_t;
endpackage

// *** pmw_seq.sv ***
// Power-mode sequencer with slow-clock watchdog.
// Assumes all inputs synchronous to clk_sys; slow clock sampled as a level.
`timescale 1ns/100ps
`default_nettype none
module pmw_seq #(
  parameter int STARTUP_CYCLES = pmw_pkg::STARTUP_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic slow_clk,
  input wire logic supply_ok,
  input wire logic stop_exec,
  input wire logic rst_pin_n,
  input wire logic adc_en,
  input wire logic protector_en,
  input wire logic interval_timer_en,
  input wire pmw_pkg::pmw_wake_t wake,
  output pmw_pkg::pmw_mode_t mode,
  output logic cpu_halt,
  output logic wd_reset,
  output logic wd_irq,
  output logic brownout_irq,
  output logic slow_clk_en,
  output logic load_pointer,
  output logic [15:0] resume_addr
);
  pmw_pkg::pmw_state_t s_r, s_nxt;
  logic slow_tick, wd_ie, wd_re, any_timer, wake_any, tmo_hit;
  logic [22:0] tmo;

  always_comb begin
    unique case (s_r.ctl[1:0])
      2'h0: tmo = pmw_pkg::WD_TMO_0;
      2'h1: tmo = pmw_pkg::WD_TMO_1;
      2'h2: tmo = pmw_pkg::WD_TMO_2;
      2'h3: tmo = pmw_pkg::WD_TMO_3;
    endcase
  end

  assign wd_ie = s_r.wdc[pmw_pkg::BIT_IE];
  assign wd_re = s_r.wdc[pmw_pkg::BIT_RE];
  assign slow_tick = slow_clk & ~s_r.slow_d;
  assign any_timer = interval_timer_en | wd_ie | wd_re;
  assign tmo_hit = s_r.wd_cnt == tmo - 23'h000001;
  assign wake_any = wake.irq_ext | wake.irq_int | ~rst_pin_n
                  | s_r.wdc[pmw_pkg::BIT_IF];

  always_comb begin
    s_nxt = s_r;
    s_nxt.slow_d = slow_clk;
    s_nxt.wd_rst = 1'b0;
    s_nxt.bo_irq = 1'b0;
    s_nxt.ld_resume = 1'b0;
    s_nxt.rdata = 8'h00;
    s_nxt.slow_analog_clock_en = wd_ie | wd_re | interval_timer_en
                  | protector_en;
    // Control bits: timeout select and brown-out irq enable only;
    // no clock divide fields exist here.
    if (reg_wr && reg_addr == pmw_pkg::CTL_OFFSET)
      s_nxt.ctl = {reg_wdata[7], 5'h00, reg_wdata[1:0]};
    if (reg_wr && reg_addr == pmw_pkg::WDC_OFFSET) begin
      s_nxt.wdc = (s_r.wdc & ~pmw_pkg::WDC_WMASK)
                | (reg_wdata & pmw_pkg::WDC_WMASK);
      s_nxt.wdc[pmw_pkg::BIT_RESTART] = 1'b0;
      // Writing zero clears the sticky flags
      for (int i = 2; i < 8; i++) begin
        if ((i == pmw_pkg::BIT_POR || i == pmw_pkg::BIT_IF
            || i == pmw_pkg::BIT_RF) && !reg_wdata[i])
          s_nxt.wdc[i] = 1'b0;
      end
    end
    if (reg_rd) begin
      if (reg_addr == pmw_pkg::WDC_OFFSET)
        s_nxt.rdata = s_r.wdc;
      else if (reg_addr == pmw_pkg::CTL_OFFSET)
        s_nxt.rdata = s_r.ctl;
    end
    // Watchdog
    if (reg_wr && reg_addr == pmw_pkg::WDC_OFFSET
        && reg_wdata[pmw_pkg::BIT_RESTART]) begin
      s_nxt.wd_cnt = '0;
      s_nxt.wd_armed = 1'b0;
      s_nxt.gap_cnt = '0;
    end else if (slow_tick && (wd_ie || wd_re)) begin
      if (!s_r.wd_armed) begin
        s_nxt.wd_cnt = s_r.wd_cnt + 23'h000001;
        if (tmo_hit) begin
          s_nxt.wd_armed = 1'b1;
          s_nxt.wdc[pmw_pkg::BIT_IF] = 1'b1;
        end
      end else if (s_r.gap_cnt == pmw_pkg::WD_RESET_GAP - 10'h001) begin
        s_nxt.wd_armed = 1'b0;
        s_nxt.gap_cnt = '0;
        s_nxt.wd_cnt = '0;
        if (wd_re) begin
          s_nxt.wd_rst = 1'b1;
          s_nxt.wdc[pmw_pkg::BIT_RF] = 1'b1;
          s_nxt.resume = pmw_pkg::RESUME_ADDR;
          s_nxt.ld_resume = 1'b1;
        end
      end else begin
        s_nxt.gap_cnt = s_r.gap_cnt + 10'h001;
      end
    end
    // Sequencer
    unique case (s_r.mode)
      pmw_pkg::PMW_BROWNOUT: begin
        s_nxt.halt = 1'b1;
        if (supply_ok) begin
          s_nxt.mode = pmw_pkg::PMW_CPU;
          s_nxt.halt = 1'b0;
          s_nxt.su_cnt = '0;
          if (s_r.su_cnt != '0 && s_r.ctl[7])
            s_nxt.bo_irq = 1'b1;
        end else if (32'(s_r.su_cnt) >= STARTUP_CYCLES - 1) begin
          s_nxt.mode = pmw_pkg::PMW_CHGWAIT;
          s_nxt.su_cnt = '0;
        end else begin
          s_nxt.su_cnt = s_r.su_cnt + 20'h00001;
        end
      end
      pmw_pkg::PMW_CPU: begin
        s_nxt.halt = 1'b0;
        if (!supply_ok) begin
          s_nxt.mode = pmw_pkg::PMW_BROWNOUT;
          s_nxt.halt = 1'b1;
          s_nxt.su_cnt = 20'h00001;
        end else if (stop_exec) begin
          s_nxt.halt = 1'b1;
          if (adc_en | protector_en | any_timer)
            s_nxt.mode = pmw_pkg::PMW_ANALOG;
          else
            s_nxt.mode = pmw_pkg::PMW_SLEEP;
        end
      end
      pmw_pkg::PMW_ANALOG: begin
        if (!supply_ok) begin
          s_nxt.mode = pmw_pkg::PMW_BROWNOUT;
          s_nxt.su_cnt = 20'h00001;
        end else if (wake_any) begin
          s_nxt.mode = pmw_pkg::PMW_CPU;
          s_nxt.halt = 1'b0;
        end
      end
      pmw_pkg::PMW_SLEEP: begin
        // Supply not watched here
        if (wake.irq_serial | wake.port_pin | wake.charger | ~rst_pin_n)
          s_nxt.mode = pmw_pkg::PMW_BROWNOUT;
      end
      pmw_pkg::PMW_CHGWAIT: begin
        if (wake.charger)
          s_nxt.mode = pmw_pkg::PMW_BROWNOUT;
      end
      default: s_nxt.mode = pmw_pkg::PMW_BROWNOUT;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.mode <= pmw_pkg::PMW_BROWNOUT;
      s_r.wdc <= pmw_pkg::WDC_RESET;
      s_r.ctl <= pmw_pkg::CTL_RESET;
      s_r.halt <= 1'b1;
      s_r.resume <= pmw_pkg::RESUME_ADDR;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata = s_r.rdata;
  assign mode = s_r.mode;
  assign cpu_halt = s_r.halt;
  assign wd_reset = s_r.wd_rst;
  assign wd_irq = s_r.wdc[pmw_pkg::BIT_IF];
  assign brownout_irq = s_r.bo_irq;
  assign slow_clk_en = s_r.slow_analog_clock_en;
  assign load_pointer = s_r.ld_resume;
  assign resume_addr = s_r.resume;

  AST_POR_BROWNOUT: assert property (@(posedge clk_sys)
    $rose(rst_n) |-> mode == pmw_pkg::PMW_BROWNOUT)
    else $error("not in brown-out after reset");
  AST_BO_TO_CPU: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mode == pmw_pkg::PMW_BROWNOUT && supply_ok |=> mode == pmw_pkg::PMW_CPU)
    else $error("brown-out did not exit");
  AST_SLEEP_ENTRY: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mode == pmw_pkg::PMW_CPU && supply_ok && stop_exec && !adc_en
    && !protector_en && !interval_timer_en && !wd_ie && !wd_re
    |=> mode == pmw_pkg::PMW_SLEEP) else $error("sleep not entered");
  AST_ANALOG_ENTRY: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mode == pmw_pkg::PMW_CPU && supply_ok && stop_exec && adc_en
    |=> mode == pmw_pkg::PMW_ANALOG) else $error("analog not entered");
  AST_DROP: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (mode == pmw_pkg::PMW_CPU || mode == pmw_pkg::PMW_ANALOG) && !supply_ok
    |=> mode == pmw_pkg::PMW_BROWNOUT && cpu_halt)
    else $error("brown-out missed");
  AST_SLEEP_STAY: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mode == pmw_pkg::PMW_SLEEP && !wake.irq_serial && !wake.port_pin
    && !wake.charger && rst_pin_n |=> mode == pmw_pkg::PMW_SLEEP)
    else $error("sleep left without wake");
  AST_CHG: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mode == pmw_pkg::PMW_CHGWAIT && wake.charger
    |=> mode == pmw_pkg::PMW_BROWNOUT) else $error("charger ignored");
  AST_WD_RST: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wd_reset |-> wd_re && s_r.wdc[pmw_pkg::BIT_RF]
    && resume_addr == pmw_pkg::RESUME_ADDR && load_pointer)
    else $error("watchdog reset malformed");
  AST_SLOW_EN: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wd_ie |=> slow_clk_en) else $error("slow clock not enabled");
  // Wake checks: reset pin and watchdog each on their own, the other sources grouped per mode
  AST_ANALOG_WAKE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mode == pmw_pkg::PMW_ANALOG && supply_ok
    && (wake.irq_ext || wake.irq_int)
    |=> mode == pmw_pkg::PMW_CPU && !cpu_halt)
    else $error("analog wake missed");
  AST_PIN_WAKE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mode == pmw_pkg::PMW_ANALOG && supply_ok && !rst_pin_n
    |=> mode == pmw_pkg::PMW_CPU) else $error("reset pin wake missed");
  AST_WD_WAKE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mode == pmw_pkg::PMW_ANALOG && supply_ok && wd_irq
    |=> mode == pmw_pkg::PMW_CPU) else $error("watchdog wake missed");
  AST_SLEEP_EXIT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mode == pmw_pkg::PMW_SLEEP
    && (wake.irq_serial || wake.port_pin || wake.charger)
    |=> mode == pmw_pkg::PMW_BROWNOUT) else $error("sleep wake missed");
  AST_BO_IRQ: assert property (@(posedge clk_sys) disable iff (!rst_n)
    brownout_irq |-> mode == pmw_pkg::PMW_CPU && s_r.ctl[7])
    else $error("brown-out irq out of place");
  AST_CHG_ENTRY: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mode == pmw_pkg::PMW_BROWNOUT && !supply_ok
    && 32'(s_r.su_cnt) >= STARTUP_CYCLES - 1
    |=> mode == pmw_pkg::PMW_CHGWAIT) else $error("charger wait missed");
  AST_RESTART: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reg_wr && reg_addr == pmw_pkg::WDC_OFFSET
    && reg_wdata[pmw_pkg::BIT_RESTART]
    |=> s_r.wd_cnt == '0 && s_r.gap_cnt == '0 && !s_r.wd_armed)
    else $error("restart did not clear counts");
  // Counter may only move on a slow edge or a restart write, never on the fast clock alone
  AST_SLOW_ONLY: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !(slow_tick && (wd_ie || wd_re))
    && !(reg_wr && reg_addr == pmw_pkg::WDC_OFFSET)
    |=> $stable(s_r.wd_cnt)) else $error("watchdog moved off slow edge");
  AST_NO_DIV: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_r.ctl[6:2] == 5'h00) else $error("divide bits present");
  AST_RESUME: assert property (@(posedge clk_sys) disable iff (!rst_n)
    load_pointer |-> wd_reset && resume_addr == pmw_pkg::RESUME_ADDR)
    else $error("resume address not loaded");
  AST_STOP_HALT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mode == pmw_pkg::PMW_CPU && supply_ok && stop_exec
    |=> cpu_halt) else $error("stop did not halt");
endmodule
`default_nettype wire

// *** pmw_core_model.sv ***
// Core and wake-source model facing the power-mode sequencer.
// Assumes the bench pulses its requests for one clock at a rising edge.
`timescale 1ns/100ps
`default_nettype none
module pmw_core_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire pmw_pkg::pmw_mode_t mode,
  input wire logic do_stop,
  input wire logic [4:0] wake_req,
  output logic stop_exec,
  output pmw_pkg::pmw_wake_t wake
);
  logic [4:0] wake_r;
  logic awake;
  assign awake = mode == pmw_pkg::PMW_CPU || mode == pmw_pkg::PMW_BROWNOUT;
  assign wake = pmw_pkg::pmw_wake_t'(wake_r);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stop_exec <= 1'b0;
      wake_r <= 5'h0;
    end else begin
      // Stop is an instruction, so it only issues while code runs
      stop_exec <= do_stop && mode == pmw_pkg::PMW_CPU;
      // Sources hold their request until the sequencer has woken
      wake_r <= awake ? wake_req : (wake_r | wake_req);
    end
  end
endmodule
`default_nettype wire

// *** pmw_seq_bench.sv ***
// Bench for the power-mode sequencer: registers, modes and watchdog.
// Assumes the core model is compiled first; the slow clock is scaled down.
`timescale 1ns/100ps
`default_nettype none
module pmw_seq_bench;
  logic clk_sys = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, slow_clk = 0;
  logic supply_ok = 0, adc_en = 0, protector_en = 0, interval_timer_en = 0;
  logic do_stop = 0, stop_exec, cpu_halt, wd_reset, wd_irq, brownout_irq;
  logic slow_clk_en, load_pointer, rst_pin_n = 1;
  logic [15:0] t0;
  logic [3:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, reg_rdata, wdc = 8'h80;
  logic [15:0] resume_addr, lfsr = 16'd46839, ticks = 0;
  logic [2:0] sc_div = 0, en;
  logic [4:0] wake_req = 0;
  pmw_pkg::pmw_wake_t wake;
  pmw_pkg::pmw_mode_t mode;
  int fails = 0, checks = 0;
  always #2.5 clk_sys = ~clk_sys;
  // Slow clock at one eighth of the system clock keeps the run short
  always @(posedge clk_sys) begin
    sc_div <= sc_div + 3'h1;
    slow_clk <= sc_div[2];
  end
  always @(posedge slow_clk) ticks <= ticks + 16'h1;
  pmw_seq #(.STARTUP_CYCLES(20)) i_pmw_seq (.clk_sys(clk_sys), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .slow_clk(slow_clk),
    .supply_ok(supply_ok), .stop_exec(stop_exec), .rst_pin_n(rst_pin_n),
    .adc_en(adc_en), .protector_en(protector_en),
    .interval_timer_en(interval_timer_en), .wake(wake), .mode(mode),
    .cpu_halt(cpu_halt), .wd_reset(wd_reset), .wd_irq(wd_irq),
    .brownout_irq(brownout_irq), .slow_clk_en(slow_clk_en),
    .load_pointer(load_pointer), .resume_addr(resume_addr));
  pmw_core_model i_pmw_core_model (.clk_sys(clk_sys), .rst_n(rst_n),
    .mode(mode), .do_stop(do_stop), .wake_req(wake_req),
    .stop_exec(stop_exec), .wake(wake));
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Flags clear on a written 0, enables follow the data, restart reads 0
  function automatic logic [7:0] wdc_exp(input logic [7:0] o, d);
    return {o[7] & d[7], d[6], 2'h0, o[3] & d[3], o[2] & d[2], d[1], 1'b0};
  endfunction
  task automatic end_of_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(16'(reg_rdata), 16'(exp));
  endtask
  task automatic pulse(input logic s, input logic [4:0] w);
    @(posedge clk_sys);
    do_stop <= s;
    wake_req <= w;
    @(posedge clk_sys);
    do_stop <= 1'b0;
    wake_req <= 5'h0;
  endtask
  task automatic wait_mode(input pmw_pkg::pmw_mode_t m);
    int n;
    for (n = 0; n < 60 && mode !== m; n++) cyc(1);
    chk(16'(mode), 16'(m));
    if (mode !== m) end_of_test();
  endtask
  task automatic wait_hi(input int w, input int lim);
    int n;
    for (n = 0; n < lim; n++) begin
      cyc(1);
      if ((w == 0 ? wd_irq : w == 1 ? wd_reset : brownout_irq) === 1'b1) return;
    end
    chk(16'h0, 16'h1);
    end_of_test();
  endtask
  initial begin
    int i;
    repeat (10) @(posedge clk_sys);
    #1;
    chk(16'(mode), 16'(pmw_pkg::PMW_BROWNOUT));
    chk(resume_addr, 16'h8000);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(4'hf, 8'h80);
    @(posedge clk_sys);
    supply_ok <= 1'b1;
    wait_mode(pmw_pkg::PMW_CPU);
    for (i = 0; i < 6; i++) begin
      lfsr = nxt(lfsr);
      wr(4'hf, lfsr[7:0]);
      wdc = wdc_exp(wdc, lfsr[7:0]);
      wr({1'b0, lfsr[10:8]}, lfsr[15:8]);
      rd(4'hf, wdc);
      rd({1'b0, lfsr[10:8]}, 8'h0);
    end
    wr(4'hf, 8'h0);
    cyc(3);
    chk(16'(slow_clk_en), 16'h0);
    for (i = 0; i < 11; i++) begin
      en = i < 8 ? i[2:0] : 3'h0;
      @(posedge clk_sys);
      {adc_en, protector_en, interval_timer_en} <= en;
      pulse(1'b1, 5'h0);
      wait_mode(en != 0 ? pmw_pkg::PMW_ANALOG : pmw_pkg::PMW_SLEEP);
      if (i == 0) begin
        supply_ok <= 1'b0;
        cyc(30);
        chk(16'(mode), 16'(pmw_pkg::PMW_SLEEP));
        @(posedge clk_sys);
        supply_ok <= 1'b1;
      end
      pulse(1'b0, en != 0 ? (en[0] ? 5'h08 : 5'h10) : 5'h04 >> (i % 3));
      wait_mode(pmw_pkg::PMW_CPU);
    end
    @(posedge clk_sys);
    adc_en <= 1'b1;
    pulse(1'b1, 5'h0);
    wait_mode(pmw_pkg::PMW_ANALOG);
    rst_pin_n <= 1'b0;
    wait_mode(pmw_pkg::PMW_CPU);
    rst_pin_n <= 1'b1;
    adc_en <= 1'b0;
    wr(4'he, 8'h80);
    rd(4'he, 8'h80);
    supply_ok <= 1'b0;
    wait_mode(pmw_pkg::PMW_BROWNOUT);
    chk(16'(cpu_halt), 16'h1);
    supply_ok <= 1'b1;
    wait_hi(2, 20);
    wait_mode(pmw_pkg::PMW_CPU);
    supply_ok <= 1'b0;
    cyc(25);
    wait_mode(pmw_pkg::PMW_CHGWAIT);
    pulse(1'b0, 5'h01);
    wait_mode(pmw_pkg::PMW_BROWNOUT);
    supply_ok <= 1'b1;
    wait_mode(pmw_pkg::PMW_CPU);
    repeat (8) if (sc_div !== 3'h0) cyc(1);
    wr(4'hf, 8'h43);
    t0 = ticks;
    cyc(2);
    chk(16'(slow_clk_en), 16'h1);
    pulse(1'b1, 5'h0);
    wait_mode(pmw_pkg::PMW_ANALOG);
    wait_hi(0, 40000);
    chk(ticks - t0, 16'd4096);
    wait_mode(pmw_pkg::PMW_CPU);
    wait_hi(1, 5000);
    chk(ticks - t0, 16'd4608);
    chk(16'(load_pointer), 16'h1);
    rd(4'hf, 8'h4e);
    end_of_test();
  end
endmodule
`default_nettype wire
